// >>> rfcfg_regs.sv
// Function
// - pulse-count code 00/01/10/11 gives 1/2/4/8 pulses; 1 and 2 BPSK only
// - subcarrier stream frequency code gives fc/64, fc/32, fc/16, fc/8
// - BPSK stream frequency code 00 gives fc/16; others reserved, host avoids
// - tx period code 000..011 gives fc/128..fc/16; top bit set reserved
// - skip-crc bit 0 checks receive crc, 1 accepts frames unchecked
// - REQA/WUPA direct commands and anticollision receive without crc check
// - phase clock shift bit selects 0 or 90 degree measurement clock
// - correlator bit 0 selects correlator reception, 1 pulse reception
// - two-bit n value feeds the initial field-on command
// - ISO-A 106k receive start needs clean first four bits unless tolerant
// - frames shorter than threshold bytes get suppression on errors
// - suppressed frame is discarded and a restart interrupt raised
`timescale 1ns/1ps
module rfcfg_regs
    import rfcfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input rfcfg_rx_evt_s rx_i,
    output rfcfg_cfg_s cfg_o,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] supp;
        logic [7:0] stream;
        logic [7:0] aux;
        logic [RFCFG_IRQ_W-1:0] irq_st;
        logic [RFCFG_IRQ_W-1:0] irq_en;
        logic ack;
        logic [31:0] rdata;
        logic auto_nocrc;
        rfcfg_cfg_s cfg;
    } rfcfg_state_s;

    rfcfg_state_s st_q;
    rfcfg_state_s st_d;

    logic req;
    logic wr_fire;
    logic [5:0] idx;
    logic [1:0] scf;
    logic [1:0] scp;
    logic [2:0] stx;
    logic [3:0] thld;
    logic bpsk;
    logic stream_mode;
    logic suppress;
    logic rxs_ok;
    logic [RFCFG_IRQ_W-1:0] evt;
    logic [RFCFG_IRQ_W-1:0] clr;

    // bus handshake: one wait cycle, then the answer
    assign req = read | write;
    assign waitrequest = req & ~st_q.ack;
    assign wr_fire = write & st_q.ack & byteenable[0];
    assign idx = address[7:2];
    assign readdata = st_q.rdata;
    assign cfg_o = st_q.cfg;
    assign irq = |(st_q.irq_st & st_q.irq_en);

    // field extraction
    assign scf = st_q.stream[RFCFG_STR_SCF_LSB +: 2];
    assign scp = st_q.stream[RFCFG_STR_SCP_LSB +: 2];
    assign stx = st_q.stream[RFCFG_STR_STX_LSB +: 3];
    assign thld = st_q.supp[RFCFG_SUP_THLD_LSB +: 4];
    assign bpsk = (rx_i.proto == RFCFG_STREAM_BPSK);
    assign stream_mode = bpsk | (rx_i.proto == RFCFG_STREAM_SC);

    // suppression of a short erroneous frame
    assign suppress = st_q.supp[RFCFG_SUP_EN_BIT] & rx_i.frame_end & rx_i.rx_err
        & (rx_i.byte_cnt < {5'h00, thld});

    // receive start for ISO-A 106k gated by the first four bits
    assign rxs_ok = rx_i.frame_start & (~(rx_i.proto == RFCFG_ISO_A & rx_i.iso_a_106)
        | ~rx_i.first4_err | st_q.supp[RFCFG_SUP_RXS_TOL_BIT]);

    // interrupt sources and clear strobes
    assign evt[RFCFG_IRQ_RX_START] = rxs_ok;
    assign evt[RFCFG_IRQ_RESTART] = suppress;
    assign evt[RFCFG_IRQ_CRC_ERR] = rx_i.frame_end & ~suppress & rx_i.crc_bad
        & st_q.cfg.crc_check;
    assign clr = (wr_fire && idx == RFCFG_IDX_IRQ_CLEAR) ?
        writedata[RFCFG_IRQ_W-1:0] : '0;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ack = req & ~st_q.ack;

        // register writes, reserved bits masked off
        if (wr_fire) begin
            case (idx)
                RFCFG_IDX_SUPPRESS: st_d.supp = writedata[7:0] & RFCFG_MASK_SUPPRESS;
                RFCFG_IDX_STREAM: st_d.stream = writedata[7:0] & RFCFG_MASK_STREAM;
                RFCFG_IDX_AUX: st_d.aux = writedata[7:0] & RFCFG_MASK_AUX;
                RFCFG_IDX_IRQ_ENABLE: st_d.irq_en = writedata[RFCFG_IRQ_W-1:0];
                default: ;
            endcase
        end

        // read data captured with the answer, unmapped reads zero
        if (read & ~st_q.ack) begin
            case (idx)
                RFCFG_IDX_SUPPRESS: st_d.rdata = {24'h000000, st_q.supp};
                RFCFG_IDX_STREAM: st_d.rdata = {24'h000000, st_q.stream};
                RFCFG_IDX_AUX: st_d.rdata = {24'h000000, st_q.aux};
                RFCFG_IDX_IRQ_STATUS: st_d.rdata = {29'h00000000, st_q.irq_st};
                RFCFG_IDX_IRQ_ENABLE: st_d.rdata = {29'h00000000, st_q.irq_en};
                default: st_d.rdata = 32'h00000000;
            endcase
        end

        // sticky status, set wins over clear
        st_d.irq_st = (st_q.irq_st & ~clr) | evt;

        // automatic no-crc after REQA/WUPA until the answer frame ends
        if (rx_i.reqa_wupa_cmd) begin
            st_d.auto_nocrc = 1'b1;
        end else if (rx_i.frame_end) begin
            st_d.auto_nocrc = 1'b0;
        end

        // subcarrier frequency and pulse count
        if (bpsk) begin
            st_d.cfg.sc_div_log2 = 3'h4;
        end else begin
            st_d.cfg.sc_div_log2 = 3'h6 - {1'b0, scf};
        end
        st_d.cfg.report_pulses = 4'h1 << scp;
        st_d.cfg.tx_div_log2 = 3'h7 - {1'b0, stx[1:0]};

        // reserved codes flagged invalid
        st_d.cfg.cfg_valid = ~stx[2] & ~(bpsk & scf != 2'h0)
            & ~((rx_i.proto == RFCFG_STREAM_SC) & ~scp[1]);

        // crc checking
        st_d.cfg.crc_check = ~st_q.aux[RFCFG_AUX_SKIP_CRC_BIT] & ~st_q.auto_nocrc
            & ~rx_i.anticoll_active;

        st_d.cfg.phase_shift = st_q.aux[RFCFG_AUX_PHASE_BIT];
        st_d.cfg.identifier_size_sel = st_q.aux[RFCFG_AUX_ID_LSB +: 2];
        st_d.cfg.init_field_n = st_q.aux[RFCFG_AUX_N_LSB +: 2];

        // receiver selection and whether the mode supports it
        st_d.cfg.use_correlator = ~st_q.aux[RFCFG_AUX_DIS_CORR_BIT];
        if (st_q.aux[RFCFG_AUX_DIS_CORR_BIT]) begin
            st_d.cfg.rx_mode_valid = stream_mode | (rx_i.proto == RFCFG_ISO_B);
        end else if (stream_mode) begin
            st_d.cfg.rx_mode_valid = (scf == 2'h1) & (scp == 2'h3);
        end else begin
            st_d.cfg.rx_mode_valid = 1'b1;
        end

        // frame outcome pulses
        st_d.cfg.rx_start = rxs_ok;
        st_d.cfg.discard = suppress;
        st_d.cfg.deliver = rx_i.frame_end & ~suppress;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.supp <= RFCFG_RST_SUPPRESS;
            st_q.stream <= RFCFG_RST_STREAM;
            st_q.aux <= RFCFG_RST_AUX;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_bus_one_wait: assert property ((read | write) & waitrequest
        |=> !waitrequest || !(read | write))
        else $error("waitrequest held beyond one cycle");

    a_stream_write_mask: assert property (write & !waitrequest & byteenable[0]
        & idx == RFCFG_IDX_STREAM |=> st_q.stream == ($past(writedata[7:0]) & 8'h7f))
        else $error("stream setup write wrong or reserved bit kept");

    a_sc_freq_map: assert property (1 |=> cfg_o.sc_div_log2 ==
        (($past(rx_i.proto) == RFCFG_STREAM_BPSK) ? 3'h4 : 3'h6 - {1'b0, $past(scf)}))
        else $error("subcarrier divider mismatch");

    a_pulse_count: assert property (1 |=> cfg_o.report_pulses == (4'h1 << $past(scp)))
        else $error("pulse count mismatch");

    a_tx_period: assert property (!stx[2] ##1 1 |-> cfg_o.tx_div_log2 ==
        3'h7 - {1'b0, $past(stx[1:0])})
        else $error("tx period mismatch");

    a_auto_nocrc: assert property (rx_i.reqa_wupa_cmd |=> ##1 !cfg_o.crc_check)
        else $error("crc checked after REQA or WUPA");

    a_skip_crc: assert property (st_q.aux[7] |=> !cfg_o.crc_check)
        else $error("crc checked while skip bit set");

    a_restart_irq: assert property (suppress |=> st_q.irq_st[RFCFG_IRQ_RESTART]
        && cfg_o.discard && !cfg_o.deliver)
        else $error("suppressed frame not discarded");

    a_rxs_gate: assert property (rx_i.frame_start & rx_i.iso_a_106
        & rx_i.proto == RFCFG_ISO_A & rx_i.first4_err & !st_q.supp[6] |=> !cfg_o.rx_start)
        else $error("receive start raised despite bad first bits");

    a_irq_clear: assert property (wr_fire & idx == RFCFG_IDX_IRQ_CLEAR
        & writedata[RFCFG_IRQ_RESTART] & !suppress |=> !st_q.irq_st[RFCFG_IRQ_RESTART])
        else $error("restart status not cleared");

    c_write_read: cover property (write & !waitrequest ##[1:4] read & !waitrequest);
    c_suppress: cover property (suppress ##1 irq);
    c_bpsk_mode: cover property (bpsk & scf == 2'h0 & stx == 3'h3);

endmodule : rfcfg_regs

// >>> rfcfg_pkg.sv
package rfcfg_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address bits 7:2)
    // ----------------------------------------------------------------
    localparam logic [5:0] RFCFG_IDX_SUPPRESS = 6'h05;
    localparam logic [5:0] RFCFG_IDX_STREAM = 6'h09;
    localparam logic [5:0] RFCFG_IDX_AUX = 6'h0a;
    localparam logic [5:0] RFCFG_IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] RFCFG_IDX_IRQ_CLEAR = 6'h11;
    localparam logic [5:0] RFCFG_IDX_IRQ_ENABLE = 6'h12;

    // ----------------------------------------------------------------
    // reset values and writable-bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RFCFG_RST_SUPPRESS = 8'h00;
    localparam logic [7:0] RFCFG_RST_STREAM = 8'h00;
    localparam logic [7:0] RFCFG_RST_AUX = 8'h00;
    localparam logic [7:0] RFCFG_MASK_SUPPRESS = 8'hcf;
    localparam logic [7:0] RFCFG_MASK_STREAM = 8'h7f;
    localparam logic [7:0] RFCFG_MASK_AUX = 8'hbf;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RFCFG_SUP_EN_BIT = 7;
    localparam int RFCFG_SUP_RXS_TOL_BIT = 6;
    localparam int RFCFG_SUP_THLD_LSB = 0;
    localparam int RFCFG_STR_SCF_LSB = 5;
    localparam int RFCFG_STR_SCP_LSB = 3;
    localparam int RFCFG_STR_STX_LSB = 0;
    localparam int RFCFG_AUX_SKIP_CRC_BIT = 7;
    localparam int RFCFG_AUX_ID_LSB = 4;
    localparam int RFCFG_AUX_PHASE_BIT = 3;
    localparam int RFCFG_AUX_DIS_CORR_BIT = 2;
    localparam int RFCFG_AUX_N_LSB = 0;

    // interrupt bit positions
    localparam int RFCFG_IRQ_RX_START = 0;
    localparam int RFCFG_IRQ_RESTART = 1;
    localparam int RFCFG_IRQ_CRC_ERR = 2;
    localparam int RFCFG_IRQ_W = 3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RFCFG_ISO_A, RFCFG_ISO_B, RFCFG_TYPE1, RFCFG_STREAM_SC, RFCFG_STREAM_BPSK
    } rfcfg_proto_e;

    // framer and encoder status toward this block
    typedef struct packed {
        rfcfg_proto_e proto;
        logic iso_a_106;
        logic frame_start;
        logic first4_err;
        logic frame_end;
        logic rx_err;
        logic crc_bad;
        logic [8:0] byte_cnt;
        logic reqa_wupa_cmd;
        logic anticoll_active;
    } rfcfg_rx_evt_s;

    // decoded configuration toward framer and encoder
    typedef struct packed {
        logic [2:0] sc_div_log2;
        logic [3:0] report_pulses;
        logic [2:0] tx_div_log2;
        logic cfg_valid;
        logic crc_check;
        logic phase_shift;
        logic use_correlator;
        logic rx_mode_valid;
        logic [1:0] identifier_size_sel;
        logic [1:0] init_field_n;
        logic rx_start;
        logic deliver;
        logic discard;
    } rfcfg_cfg_s;

endpackage : rfcfg_pkg

// >>> rfcfg_regs_test.sv
`timescale 1ns/1ps
module rfcfg_regs_test;
    import rfcfg_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic [3:0] byteenable;
    logic waitrequest;
    logic irq;
    rfcfg_rx_evt_s rx_i;
    rfcfg_cfg_s cfg_o;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] q;

    rfcfg_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .rx_i(rx_i), .cfg_o(cfg_o), .irq(irq));

    // free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            #1;
            if (waitrequest === 1'b0) break;
            @(posedge ref_clk);
        end
        if (i == 20) begin
            n_fail++;
            close_out();
        end
        @(posedge ref_clk);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    task rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask : rdc

    task settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    // one framer event, pulses dropped after one cycle
    task fr(input logic s, input logic e, input logic f4, input logic er, input logic [8:0] n);
        @(posedge ref_clk);
        rx_i.frame_start <= s;
        rx_i.frame_end <= e;
        rx_i.first4_err <= f4;
        rx_i.rx_err <= er;
        rx_i.byte_cnt <= n;
        @(posedge ref_clk);
        rx_i.frame_start <= 1'b0;
        rx_i.frame_end <= 1'b0;
        #1;
    endtask : fr

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        rdc("supp_rst", 8'h14, 8'h00);
        rdc("strm_rst", 8'h24, 8'h00);
        rdc("aux_rst", 8'h28, 8'h00);
        bus(1'b1, 8'h14, 8'hff);
        bus(1'b1, 8'h24, 8'hff);
        bus(1'b1, 8'h28, 8'hff);
        rdc("supp_mask", 8'h14, 8'hcf);
        rdc("strm_mask", 8'h24, 8'h7f);
        rdc("aux_mask", 8'h28, 8'hbf);
        bus(1'b1, 8'h3c, 8'hff);
        rdc("unmapped", 8'h3c, 8'h00);
        byteenable <= 4'h0;
        bus(1'b1, 8'h24, 8'h00);
        byteenable <= 4'h1;
        rdc("be_off", 8'h24, 8'h7f);
        bus(1'b1, 8'h14, 8'h00);
        bus(1'b1, 8'h28, 8'h00);
    endtask : t_regs

    task t_stream;
        rx_i.proto <= RFCFG_STREAM_SC;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'h24, {1'b0, 2'(k), 5'b11000});
            settle();
            chk("sc_div", 6 - k, cfg_o.sc_div_log2);
            chk("pulses8", 8, cfg_o.report_pulses);
        end
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, 8'h24, {5'b00011, 3'(k)});
            settle();
            if (k < 4) chk("tx_div", 7 - k, cfg_o.tx_div_log2);
            chk("tx_valid", k < 4, cfg_o.cfg_valid);
        end
        bus(1'b1, 8'h24, 8'h08);
        settle();
        chk("sc_scp1", 0, cfg_o.cfg_valid);
        rx_i.proto <= RFCFG_STREAM_BPSK;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'h24, {3'b000, 2'(k), 3'b000});
            settle();
            chk("bpsk_pulses", 1 << k, cfg_o.report_pulses);
            chk("bpsk_div", 4, cfg_o.sc_div_log2);
        end
        bus(1'b1, 8'h24, 8'h20);
        settle();
        chk("bpsk_rsvd", 0, cfg_o.cfg_valid);
    endtask : t_stream

    task t_aux;
        rx_i.proto <= RFCFG_ISO_B;
        bus(1'b1, 8'h28, 8'h00);
        settle();
        chk("crc_on", 1, cfg_o.crc_check);
        chk("ph0", 0, cfg_o.phase_shift);
        chk("corr", 1, cfg_o.use_correlator);
        bus(1'b1, 8'h28, 8'h9f);
        settle();
        chk("crc_off", 0, cfg_o.crc_check);
        chk("ph90", 1, cfg_o.phase_shift);
        chk("pulse_rx", 0, cfg_o.use_correlator);
        chk("n_val", 3, cfg_o.init_field_n);
        chk("id_sel", 1, cfg_o.identifier_size_sel);
        bus(1'b1, 8'h28, 8'h00);
        @(posedge ref_clk);
        rx_i.reqa_wupa_cmd <= 1'b1;
        @(posedge ref_clk);
        rx_i.reqa_wupa_cmd <= 1'b0;
        settle();
        chk("reqa_nocrc", 0, cfg_o.crc_check);
        fr(1'b0, 1'b1, 1'b0, 1'b0, 9'h5);
        settle();
        chk("crc_back", 1, cfg_o.crc_check);
        rx_i.anticoll_active <= 1'b1;
        settle();
        chk("ac_nocrc", 0, cfg_o.crc_check);
        rx_i.anticoll_active <= 1'b0;
    endtask : t_aux

    task t_frames;
        rx_i.proto <= RFCFG_ISO_A;
        rx_i.iso_a_106 <= 1'b1;
        bus(1'b1, 8'h44, 8'h07);
        fr(1'b1, 1'b0, 1'b1, 1'b0, 9'h0);
        chk("rxs_err", 0, cfg_o.rx_start);
        fr(1'b1, 1'b0, 1'b0, 1'b0, 9'h0);
        chk("rxs_ok", 1, cfg_o.rx_start);
        bus(1'b1, 8'h14, 8'h40);
        fr(1'b1, 1'b0, 1'b1, 1'b0, 9'h0);
        chk("rxs_tol", 1, cfg_o.rx_start);
        bus(1'b0, 8'h40, 8'h00);
        chk("st_rxs", 1, q[0]);
        bus(1'b1, 8'h48, 8'h02);
        bus(1'b1, 8'h14, 8'hc4);
        fr(1'b0, 1'b1, 1'b0, 1'b1, 9'h4);
        chk("thld_edge", 0, cfg_o.discard);
        fr(1'b0, 1'b1, 1'b0, 1'b1, 9'h3);
        chk("discard", 1, cfg_o.discard);
        chk("no_deliv", 0, cfg_o.deliver);
        chk("irq_on", 1, irq);
        bus(1'b1, 8'h48, 8'h00);
        #1;
        chk("irq_mask", 0, irq);
        bus(1'b1, 8'h48, 8'h02);
        #1;
        chk("irq_unmask", 1, irq);
        bus(1'b1, 8'h44, 8'h02);
        #1;
        chk("irq_clr", 0, irq);
        rdc("st_clr", 8'h40, 8'h01);
        bus(1'b1, 8'h14, 8'h04);
        fr(1'b0, 1'b1, 1'b0, 1'b1, 9'h3);
        chk("supp_off", 0, cfg_o.discard);
    endtask : t_frames

    // reset, then the scenarios in turn
    initial begin
        resetn = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h1;
        rx_i = '0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_stream();
        t_aux();
        t_frames();
        close_out();
    end
endmodule : rfcfg_regs_test
